// ### hw/phase_chain_pkg.sv
// constants and types shared by the phase end and the controller end
// assumes one core clock at 40 MHz and a synchronous active-high reset
package phase_chain_pkg;
  localparam int unsigned CORE_CLK_HZ = 40_000_000;
  localparam int unsigned SYS_CLK_MIN_HZ = 250_000;
  localparam int unsigned SYS_CLK_MAX_HZ = 9_000_000;
  // half period of the system clock in core cycles
  localparam int unsigned HALF_W = 8;
  localparam logic [HALF_W-1:0] HALF_MIN =
    HALF_W'((CORE_CLK_HZ + 2 * SYS_CLK_MAX_HZ - 1) / (2 * SYS_CLK_MAX_HZ));
  localparam logic [HALF_W-1:0] HALF_MAX = HALF_W'(CORE_CLK_HZ / (2 * SYS_CLK_MIN_HZ));
  localparam logic [HALF_W-1:0] HALF_RESET = HALF_MAX;
  // light load entry
  localparam logic [3:0] LIGHT_LOAD_TOKEN_CYCLES = 4'h8;
  // calibration ripple
  localparam int unsigned CAL_DIVIDE = 896;
  localparam int unsigned CAL_W = 9;
  localparam logic [CAL_W-1:0] CAL_HALF_LAST = CAL_W'(CAL_DIVIDE / 2 - 1);
  // phase discovery
  localparam int unsigned PHASE_W = 5;
  localparam logic [PHASE_W-1:0] MAX_PHASES = 5'h10;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 5'h00;

  typedef enum logic [1:0] {
    GATE_LOW_ON,
    GATE_BREAK_LOW,
    GATE_HIGH_ON,
    GATE_BREAK_HIGH
  } gate_state_e;

  typedef enum logic [1:0] {
    CTL_START,
    CTL_DISCOVER,
    CTL_RUN,
    CTL_BROKEN
  } ctl_state_e;
endpackage

// ### hw/phase_link_if.sv
// one controller-to-phase link: shared system clock and token both ways
// assumes the bench chains several links to form the daisy chain
`timescale 1ns/1ps
interface phase_link_if;
  logic sys_clock;
  logic token_fwd;
  logic token_back;

  modport controller_end (
    output sys_clock,
    output token_fwd,
    input token_back
  );

  modport phase_end (
    input sys_clock,
    input token_fwd,
    output token_back
  );
endinterface

// ### hw/phase_end.sv
// switching logic of one converter phase: latch, gate sequencing, token flop
// assumes comparator outputs and the system clock arrive synchronous to core_clk
`timescale 1ns/1ps
module phase_end
  import phase_chain_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  phase_link_if.phase_end link,
  input wire logic light_load_indicator_n,
  input wire logic ramp_above_demand,
  input wire logic demand_above_range,
  input wire logic demand_below_share,
  input wire logic low_gate_below_1v,
  input wire logic switch_node_below_1v,
  output logic high_side_drive,
  output logic high_side_en,
  output logic low_side_drive,
  output logic low_side_en,
  output logic ramp_run,
  output logic ramp_discharge,
  output logic light_load_synced,
  output logic cal_ripple
);
  logic clk_prev;
  logic token_prev;
  logic token_delay_flop;
  logic pwm_latch;
  logic [3:0] token_count;
  logic [CAL_W-1:0] cal_count;
  gate_state_e gate_state;
  logic next_clk_prev;
  logic next_token_prev;
  logic next_token_delay_flop;
  logic next_pwm_latch;
  logic [3:0] next_token_count;
  logic [CAL_W-1:0] next_cal_count;
  logic next_cal_ripple;
  logic next_synced;
  gate_state_e next_gate_state;
  logic next_high;
  logic next_low;
  logic next_en;
  logic clk_fall;
  logic token_rise;
  logic cycle_start;
  logic latch_set;
  logic latch_reset;

  // system clock falling edge and token rising edge
  assign clk_fall = clk_prev & ~link.sys_clock;
  assign token_rise = link.token_fwd & ~token_prev;
  // own cycle begins at the clock fall that meets the token
  assign cycle_start = clk_fall & link.token_fwd & ~light_load_synced;
  assign latch_set = cycle_start;
  // full demand masks the ramp comparator
  assign latch_reset = ramp_above_demand & ~demand_above_range;

  // token pass-through or one clock delay
  assign link.token_back = light_load_synced ? link.token_fwd : token_delay_flop;

  always_comb begin
    next_clk_prev = link.sys_clock;
    next_token_prev = link.token_fwd;
    next_token_delay_flop = token_delay_flop;
    if (clk_fall && !light_load_synced) begin
      next_token_delay_flop = link.token_fwd;
    end
    if (light_load_synced) begin
      next_token_delay_flop = 1'b0;
    end
    // reset dominant latch
    if (latch_reset) begin
      next_pwm_latch = 1'b0;
    end else if (latch_set) begin
      next_pwm_latch = 1'b1;
    end else begin
      next_pwm_latch = pwm_latch;
    end
    if (light_load_synced) begin
      next_pwm_latch = 1'b0;
    end
  end

  // light load entry: count token cycles, then wait for a clock fall
  always_comb begin
    next_token_count = token_count;
    next_synced = light_load_synced;
    if (light_load_indicator_n) begin
      next_token_count = 4'h0;
      next_synced = 1'b0;
    end else if (!light_load_synced) begin
      if (token_count != LIGHT_LOAD_TOKEN_CYCLES) begin
        if (token_rise) begin
          next_token_count = token_count + 4'h1;
        end
      end else if (clk_fall) begin
        next_synced = 1'b1;
      end
    end
  end

  // break-before-make gate sequencing
  always_comb begin
    next_gate_state = gate_state;
    case (gate_state)
      GATE_LOW_ON: begin
        if (next_pwm_latch) begin
          next_gate_state = GATE_BREAK_LOW;
        end
      end
      GATE_BREAK_LOW: begin
        if (!next_pwm_latch) begin
          next_gate_state = GATE_BREAK_HIGH;
        end else if (low_gate_below_1v) begin
          next_gate_state = GATE_HIGH_ON;
        end
      end
      GATE_HIGH_ON: begin
        if (!next_pwm_latch) begin
          next_gate_state = GATE_BREAK_HIGH;
        end
      end
      GATE_BREAK_HIGH: begin
        if (next_pwm_latch) begin
          next_gate_state = GATE_BREAK_LOW;
        end else if (switch_node_below_1v) begin
          next_gate_state = GATE_LOW_ON;
        end
      end
      default: begin
        next_gate_state = GATE_BREAK_HIGH;
      end
    endcase
    if (next_synced) begin
      next_gate_state = GATE_BREAK_HIGH;
    end
    next_high = (next_gate_state == GATE_HIGH_ON);
    // falling demand cuts the low side
    next_low = (next_gate_state == GATE_LOW_ON) & ~demand_below_share;
    next_en = ~next_synced;
  end

  // calibration ripple: one full period per 896 own cycles
  always_comb begin
    next_cal_count = cal_count;
    next_cal_ripple = cal_ripple;
    if (cycle_start) begin
      if (cal_count == CAL_HALF_LAST) begin
        next_cal_count = '0;
        next_cal_ripple = ~cal_ripple;
      end else begin
        next_cal_count = cal_count + CAL_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clk_prev <= 1'b0;
      token_prev <= 1'b0;
      token_delay_flop <= 1'b0;
      pwm_latch <= 1'b0;
      token_count <= 4'h0;
      light_load_synced <= 1'b0;
      gate_state <= GATE_BREAK_HIGH;
      high_side_drive <= 1'b0;
      low_side_drive <= 1'b0;
      high_side_en <= 1'b1;
      low_side_en <= 1'b1;
      ramp_run <= 1'b0;
      ramp_discharge <= 1'b1;
      cal_count <= '0;
      cal_ripple <= 1'b0;
    end else begin
      clk_prev <= next_clk_prev;
      token_prev <= next_token_prev;
      token_delay_flop <= next_token_delay_flop;
      pwm_latch <= next_pwm_latch;
      token_count <= next_token_count;
      light_load_synced <= next_synced;
      gate_state <= next_gate_state;
      high_side_drive <= next_high;
      low_side_drive <= next_low;
      high_side_en <= next_en;
      low_side_en <= next_en;
      ramp_run <= next_pwm_latch;
      ramp_discharge <= ~next_pwm_latch;
      cal_count <= next_cal_count;
      cal_ripple <= next_cal_ripple;
    end
  end
endmodule

// ### hw/controller_end.sv
// controller side of the chain: system clock divider, token source, discovery
// assumes one clock output fans out to every phase and the chain returns here
`timescale 1ns/1ps
module controller_end
  import phase_chain_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  phase_link_if.controller_end link,
  input wire logic [HALF_W-1:0] clock_half_period,
  output logic [PHASE_W-1:0] phase_count,
  output logic chain_broken,
  output logic chain_ready
);
  logic sys_clock;
  logic token;
  logic [HALF_W-1:0] div_count;
  logic [PHASE_W-1:0] slot;
  ctl_state_e state;
  logic [HALF_W-1:0] half_limit;
  logic next_sys_clock;
  logic next_token;
  logic [HALF_W-1:0] next_div_count;
  logic [PHASE_W-1:0] next_slot;
  logic [PHASE_W-1:0] next_phase_count;
  ctl_state_e next_state;
  logic fall_now;

  assign link.sys_clock = sys_clock;
  assign link.token_fwd = token;
  assign chain_broken = (state == CTL_BROKEN);
  assign chain_ready = (state == CTL_RUN);

  // settable rate held inside the legal range
  always_comb begin
    half_limit = clock_half_period;
    if (clock_half_period < HALF_MIN) begin
      half_limit = HALF_MIN;
    end else if (clock_half_period > HALF_MAX) begin
      half_limit = HALF_MAX;
    end
  end

  always_comb begin
    next_div_count = div_count + HALF_W'(1);
    next_sys_clock = sys_clock;
    fall_now = 1'b0;
    if (div_count >= half_limit - HALF_W'(1)) begin
      next_div_count = '0;
      next_sys_clock = ~sys_clock;
      fall_now = sys_clock;
    end
    next_token = token;
    next_slot = slot;
    next_phase_count = phase_count;
    next_state = state;
    case (state)
      CTL_START: begin
        if (fall_now) begin
          next_token = 1'b1;
          next_slot = '0;
          next_state = CTL_DISCOVER;
        end
      end
      CTL_DISCOVER: begin
        if (fall_now) begin
          next_token = 1'b0;
          if (link.token_back) begin
            // first phase answers in the launch period, so count the return fall too
            next_phase_count = slot + PHASE_W'(1);
            next_slot = '0;
            next_state = CTL_RUN;
          end else if (slot == MAX_PHASES) begin
            next_state = CTL_BROKEN;
          end else begin
            next_slot = slot + PHASE_W'(1);
          end
        end
      end
      CTL_RUN: begin
        // one token per phase_count clocks: clock is switching rate times phases
        if (fall_now) begin
          next_token = (slot == '0);
          next_slot = (slot == phase_count - PHASE_W'(1)) ? '0 : slot + PHASE_W'(1);
        end
      end
      CTL_BROKEN: begin
        if (fall_now) begin
          next_token = 1'b0;
        end
      end
      default: begin
        next_state = CTL_START;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sys_clock <= 1'b0;
      token <= 1'b0;
      div_count <= '0;
      slot <= '0;
      phase_count <= PHASE_RESET;
      state <= CTL_START;
    end else begin
      sys_clock <= next_sys_clock;
      token <= next_token;
      div_count <= next_div_count;
      slot <= next_slot;
      phase_count <= next_phase_count;
      state <= next_state;
    end
  end
endmodule

// ### verif/phase_chain_assertions.sv
// checker for the first phase link and the drives of that phase
// assumes core_clk and rst are shared by every end of the chain
`timescale 1ns/1ps
module phase_chain_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sys_clock,
  input wire logic token_fwd,
  input wire logic token_back,
  input wire logic ramp_above_demand,
  input wire logic demand_above_range,
  input wire logic demand_below_share,
  input wire logic low_gate_below_1v,
  input wire logic switch_node_below_1v,
  input wire logic light_load_indicator_n,
  input wire logic high_side_drive,
  input wire logic high_side_en,
  input wire logic low_side_drive,
  input wire logic low_side_en,
  input wire logic ramp_run,
  input wire logic light_load_synced
);
  logic sys_q;
  logic fall;
  logic start;
  logic clr;
  assign fall = sys_q & ~sys_clock;
  assign start = fall & token_fwd & ~light_load_synced;
  assign clr = ramp_above_demand & ~demand_above_range;
  always_ff @(posedge core_clk) begin
    sys_q <= sys_clock;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  latch_set_a: assert property (start && !clr |=> ramp_run || light_load_synced)
    else $error("latch not set on token fall");
  reset_wins_a: assert property (clr |=> !ramp_run)
    else $error("latch not cleared by ramp");
  turn_on_gated_a: assert property ($rose(ramp_run) |-> $past(start))
    else $error("latch set off a clock fall");
  full_duty_a: assert property (ramp_run && demand_above_range |=>
    ramp_run || light_load_synced)
    else $error("latch cleared at full demand");
  high_make_a: assert property ($rose(high_side_drive) |->
    $past(low_gate_below_1v) && !low_side_drive && ramp_run)
    else $error("high drive on too early");
  low_make_a: assert property ($rose(low_side_drive) |-> $past(switch_node_below_1v)
    && !high_side_drive && !$past(demand_below_share))
    else $error("low drive on too early");
  high_break_a: assert property ($fell(ramp_run) |-> !high_side_drive)
    else $error("high drive outlived latch");
  brake_low_a: assert property (demand_below_share |-> ##[1:2] !low_side_drive)
    else $error("low drive kept on below share");
  token_delay_a: assert property (fall && !light_load_synced |=>
    light_load_synced || token_back == $past(token_fwd))
    else $error("token not delayed one clock");
  bypass_a: assert property (light_load_synced |-> token_back == token_fwd && !high_side_en
    && !low_side_en && !high_side_drive && !low_side_drive)
    else $error("light load not bypassed");
  sync_entry_a: assert property ($rose(light_load_synced) |->
    $past(fall) && !$past(light_load_indicator_n))
    else $error("sync flag set off a fall");
  sync_exit_a: assert property (light_load_indicator_n && light_load_synced |=>
    !light_load_synced)
    else $error("sync flag kept after exit");
endmodule

// ### verif/multiphase_pwm_phase_logic_tb.sv
// bench: controller, two chained phases, and a controller with an open chain
// assumes one core clock for every end; chain links joined by assigns
`timescale 1ns/1ps
module multiphase_pwm_phase_logic_tb;
  import phase_chain_pkg::*;
  logic core_clk, rst, light_load_indicator_n, ramp_above_demand, demand_above_range;
  logic demand_below_share, low_gate_below_1v, switch_node_below_1v;
  logic high_side_drive, high_side_en, low_side_drive, low_side_en, ramp_run;
  logic ramp_discharge, light_load_synced, cal_ripple, chain_broken, chain_ready, broken_x;
  logic [HALF_W-1:0] clock_half_period;
  logic [PHASE_W-1:0] phase_count;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  phase_link_if link_c();
  phase_link_if link_p1();
  phase_link_if link_p2();
  phase_link_if link_x();
  assign link_p1.sys_clock = link_c.sys_clock;
  assign link_p1.token_fwd = link_c.token_fwd;
  assign link_p2.sys_clock = link_c.sys_clock;
  assign link_p2.token_fwd = link_p1.token_back;
  assign link_c.token_back = link_p2.token_back;
  assign link_x.token_back = 1'b0;
  controller_end u_controller_end (.core_clk, .rst, .link(link_c.controller_end),
    .clock_half_period, .phase_count, .chain_broken, .chain_ready);
  controller_end u_controller_end_x (.core_clk, .rst, .link(link_x.controller_end),
    .clock_half_period, .phase_count(), .chain_broken(broken_x), .chain_ready());
  phase_end u_phase_end (.core_clk, .rst, .link(link_p1.phase_end), .light_load_indicator_n,
    .ramp_above_demand, .demand_above_range, .demand_below_share, .low_gate_below_1v,
    .switch_node_below_1v, .high_side_drive, .high_side_en, .low_side_drive, .low_side_en,
    .ramp_run, .ramp_discharge, .light_load_synced, .cal_ripple);
  phase_end u_phase_end_2 (.core_clk, .rst, .link(link_p2.phase_end),
    .light_load_indicator_n(1'b1), .ramp_above_demand, .demand_above_range,
    .demand_below_share, .low_gate_below_1v, .switch_node_below_1v, .high_side_drive(),
    .high_side_en(), .low_side_drive(), .low_side_en(), .ramp_run(), .ramp_discharge(),
    .light_load_synced(), .cal_ripple());
  phase_chain_assertions u_phase_chain_assertions (.core_clk, .rst,
    .sys_clock(link_p1.sys_clock), .token_fwd(link_p1.token_fwd),
    .token_back(link_p1.token_back), .ramp_above_demand, .demand_above_range,
    .demand_below_share, .low_gate_below_1v, .switch_node_below_1v, .light_load_indicator_n,
    .high_side_drive, .high_side_en, .low_side_drive, .low_side_en, .ramp_run,
    .light_load_synced);
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic t_discover();
    for (int i = 0; i < 3000 && chain_ready !== 1'b1; i++) wait_cyc(1);
    chk1("chain_ready", 1'b1, chain_ready);
    chk8("phase_count", 8'h02, 8'(phase_count));
    chk1("chain_broken", 1'b0, chain_broken);
    for (int i = 0; i < 3000 && broken_x !== 1'b1; i++) wait_cyc(1);
    chk1("open chain_broken", 1'b1, broken_x);
    $display("test discover done");
  endtask
  task automatic t_pwm();
    ramp_above_demand = 1'b0;
    for (int i = 0; i < 400 && ramp_run !== 1'b1; i++) wait_cyc(1);
    chk1("ramp_run", 1'b1, ramp_run);
    wait_cyc(3);
    chk1("high before gate low", 1'b0, high_side_drive);
    low_gate_below_1v = 1'b1;
    wait_cyc(3);
    chk1("high after gate low", 1'b1, high_side_drive);
    ramp_above_demand = 1'b1;
    wait_cyc(2);
    chk1("ramp_run cleared", 1'b0, ramp_run);
    chk1("ramp_discharge", 1'b1, ramp_discharge);
    chk1("high off", 1'b0, high_side_drive);
    wait_cyc(3);
    chk1("low before switch", 1'b0, low_side_drive);
    switch_node_below_1v = 1'b1;
    wait_cyc(3);
    chk1("low after switch", 1'b1, low_side_drive);
    wait_cyc(60);
    chk1("latch held clear", 1'b0, ramp_run);
    $display("test pwm done");
  endtask
  task automatic t_full();
    demand_above_range = 1'b1;
    for (int i = 0; i < 400 && ramp_run !== 1'b1; i++) wait_cyc(1);
    chk1("full ramp_run", 1'b1, ramp_run);
    chk1("low off at set", 1'b0, low_side_drive);
    wait_cyc(60);
    chk1("full duty held", 1'b1, ramp_run);
    demand_above_range = 1'b0;
    wait_cyc(3);
    chk1("full released", 1'b0, ramp_run);
    $display("test full duty done");
  endtask
  task automatic t_brake();
    wait_cyc(3);
    chk1("low before brake", 1'b1, low_side_drive);
    demand_below_share = 1'b1;
    wait_cyc(3);
    chk1("low in brake", 1'b0, low_side_drive);
    demand_below_share = 1'b0;
    $display("test brake done");
  endtask
  task automatic t_light();
    light_load_indicator_n = 1'b0;
    wait_cyc(40);
    chk1("synced early", 1'b0, light_load_synced);
    for (int i = 0; i < 800 && light_load_synced !== 1'b1; i++) wait_cyc(1);
    chk1("synced", 1'b1, light_load_synced);
    chk1("high_side_en", 1'b0, high_side_en);
    chk1("low_side_en", 1'b0, low_side_en);
    for (int i = 0; i < 4; i++) begin
      wait_cyc(5);
      chk1("token bypass", link_p1.token_fwd, link_p1.token_back);
    end
    light_load_indicator_n = 1'b1;
    wait_cyc(2);
    chk1("synced exit", 1'b0, light_load_synced);
    $display("test light load done");
  endtask
  task automatic t_cal();
    logic c;
    logic [15:0] n;
    c = cal_ripple;
    for (int i = 0; i < 8000 && cal_ripple === c; i++) wait_cyc(1);
    c = cal_ripple;
    n = 16'h0000;
    while (cal_ripple === c && n != 16'hffff) begin
      wait_cyc(1);
      n++;
    end
    // half of 896 own cycles, two phases, system period of two halves of 4
    chk16("cal half period", 16'(CAL_DIVIDE / 2 * 2 * 2 * 4), n);
    $display("test calibration done");
  endtask
  task automatic t_clock(input logic [7:0] req, input logic [7:0] exp);
    logic [7:0] m;
    logic s;
    clock_half_period = req;
    for (int i = 0; i < 3; i++) begin
      s = link_c.sys_clock;
      m = 8'h00;
      while (link_c.sys_clock === s && m != 8'hff) begin
        wait_cyc(1);
        m++;
      end
    end
    chk8("half period", exp, m);
    $display("test clock %h done", req);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    rst = 1'b1;
    clock_half_period = 8'h04;
    light_load_indicator_n = 1'b1;
    ramp_above_demand = 1'b1;
    demand_above_range = 1'b0;
    demand_below_share = 1'b0;
    low_gate_below_1v = 1'b0;
    switch_node_below_1v = 1'b0;
    wait_cyc(8);
    rst = 1'b0;
    t_discover();
    t_pwm();
    t_full();
    t_brake();
    t_light();
    t_cal();
    t_clock(8'h02, 8'h03);
    t_clock(8'h0a, 8'h0a);
    t_clock(8'h64, 8'h50);
    final_report();
  end
endmodule
